// File: src/lsmtr_pkg.sv
// shared constants, types and encodings of the supply monitor and torch register bank
package lsmtr_pkg;

  // ==========================================================================
  // register addresses
  localparam logic [7:0] SUPPLY_CFG_ADDR = 8'h80;
  localparam logic [7:0] LAST_LEVEL_ADDR = 8'h81;
  localparam logic [7:0] TORCH_ADDR      = 8'hA0;
  localparam logic [7:0] FLAGS_ADDR      = 8'hD0;
  localparam logic [7:0] UNMAPPED_DATA   = 8'h00;

  // ==========================================================================
  // values after reset
  localparam logic [5:0] SUPPLY_CFG_RST  = 6'h00;
  localparam logic [5:0] TORCH_RST       = 6'h12;
  localparam logic [7:0] LAST_LEVEL_RST  = 8'h00;
  localparam logic [2:0] FLAGS_RST       = 3'h0;

  // ==========================================================================
  // fault flag positions in the flags byte
  localparam int unsigned FLAG_THERM_BIT  = 4;
  localparam int unsigned FLAG_STEADY_BIT = 5;
  localparam int unsigned FLAG_FLASH_BIT  = 6;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS      = 100;
  localparam int unsigned STEADY_DEGLITCH_US = 250;
  localparam int unsigned FLASH_DEGLITCH_US  = 8;
  localparam int unsigned STEADY_CYCLES      =
    (STEADY_DEGLITCH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FLASH_CYCLES       =
    (FLASH_DEGLITCH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEGLITCH_CNT_W     = 12;

  // ==========================================================================
  // serial bus
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_ADDR     = 4'b0001,
    ST_ACK_ADDR = 4'b0010,
    ST_REG      = 4'b0011,
    ST_ACK_REG  = 4'b0100,
    ST_WDATA    = 4'b0101,
    ST_ACK_WR   = 4'b0110,
    ST_RDATA    = 4'b0111,
    ST_RACK     = 4'b1000
  } lsmtr_bus_state_t;

  // ==========================================================================
  // register layouts
  typedef enum logic [1:0] {
    TH_2V9 = 2'b00,
    TH_3V0 = 2'b01,
    TH_3V1 = 2'b10,
    TH_3V2 = 2'b11
  } lsmtr_thresh_t;

  typedef struct packed {
    lsmtr_thresh_t flash_supply_threshold;
    logic          flash_monitor_en;
    lsmtr_thresh_t steady_supply_threshold;
    logic          steady_monitor_en;
  } lsmtr_supply_cfg_t;

  typedef struct packed {
    logic [2:0] torch_led2_code;
    logic [2:0] torch_led1_code;
  } lsmtr_torch_t;

  typedef struct packed {
    logic flash_trip;
    logic steady_trip;
    logic therm_trip;
  } lsmtr_flags_t;

endpackage : lsmtr_pkg

// File: src/lsmtr_deglitch.sv
// qualification timer: fires once when a level has stood high for a set number of cycles
`timescale 1ns/1ns

module lsmtr_deglitch #(
  parameter int unsigned CYCLES = 80,
  parameter int unsigned CNT_W  = 12
) (
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  input  wire logic enable_in,
  input  wire logic level_in,
  output logic      fire_out
);

  localparam logic [CNT_W-1:0] LIMIT     = CNT_W'(CYCLES);
  localparam logic [CNT_W-1:0] LIMIT_M1  = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_reg;
  logic             fire_reg;

  // ==========================================================================
  // qualification count, saturates so one trip gives one pulse
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !enable_in || !level_in) begin
      cnt_reg <= '0;
    end else if (cnt_reg != LIMIT) begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      fire_reg <= 1'b0;
    end else begin
      fire_reg <= enable_in && level_in && (cnt_reg == LIMIT_M1);
    end
  end

  assign fire_out = fire_reg;

  // ==========================================================================
  // checks
  fire_after_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    fire_reg |-> $past(cnt_reg) == LIMIT_M1 && $past(level_in) && $past(enable_in))
    else $error("deglitch fired before the full hold time");

  fire_once_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    fire_reg |=> !fire_reg)
    else $error("deglitch fired twice for one trip");

endmodule : lsmtr_deglitch

// File: src/lsmtr_regs.sv
// supply monitor configuration, last flash level capture and torch current registers
`timescale 1ns/1ns

module lsmtr_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  input  wire logic                       core_clk_in,
  input  wire logic                       rst_in,
  input  wire logic                       scl_in,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe_out,
  input  wire logic [7:0]                 flash_code_in,
  input  wire logic                       thermistor_sensing_in,
  input  wire logic                       thermistor_trip_in,
  input  wire logic                       steady_supply_low_in,
  input  wire logic                       flash_supply_low_in,
  output lsmtr_pkg::lsmtr_supply_cfg_t    supply_cfg_out,
  output lsmtr_pkg::lsmtr_torch_t         torch_cfg_out,
  output logic [7:0]                      last_level_out,
  output lsmtr_pkg::lsmtr_flags_t         fault_flags_out
);

  // ==========================================================================
  // pin synchronisers
  logic scl_meta, scl_sync, scl_prev;
  logic sda_meta, sda_sync, sda_prev;
  logic therm_meta, therm_sync;
  logic stdy_meta, stdy_sync;
  logic fls_meta, fls_sync;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      {scl_meta, scl_sync, scl_prev} <= 3'h7;
      {sda_meta, sda_sync, sda_prev} <= 3'h7;
      {therm_meta, therm_sync}       <= 2'h0;
      {stdy_meta, stdy_sync}         <= 2'h0;
      {fls_meta, fls_sync}           <= 2'h0;
    end else begin
      {scl_meta, scl_sync, scl_prev} <= {scl_in, scl_meta, scl_sync};
      {sda_meta, sda_sync, sda_prev} <= {sda_in, sda_meta, sda_sync};
      {therm_meta, therm_sync}       <= {thermistor_trip_in, therm_meta};
      {stdy_meta, stdy_sync}         <= {steady_supply_low_in, stdy_meta};
      {fls_meta, fls_sync}           <= {flash_supply_low_in, fls_meta};
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise  = scl_sync && !scl_prev;
  assign scl_fall  = !scl_sync && scl_prev;
  assign start_det = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign stop_det  = scl_sync && scl_prev && !sda_prev && sda_sync;

  // ==========================================================================
  // register storage
  lsmtr_pkg::lsmtr_supply_cfg_t supply_cfg_reg;
  lsmtr_pkg::lsmtr_torch_t      torch_reg;
  logic [7:0]                   last_level_reg;
  lsmtr_pkg::lsmtr_flags_t      flags_reg;
  lsmtr_pkg::lsmtr_flags_t      fire;
  logic                         fire_therm, fire_steady, fire_flash;
  logic                         any_fire;

  // ==========================================================================
  // serial bus slave
  lsmtr_pkg::lsmtr_bus_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] ptr_reg;
  logic       rw_reg;
  logic       ack_ok_reg;
  logic       sda_oe_reg;
  logic       sda_o_reg;
  logic       wr_stb_reg;
  logic [7:0] wr_ptr_reg;
  logic [7:0] wr_data_reg;
  logic       flag_clr_reg;
  logic [7:0] rd_data;

  always_comb begin
    rd_data = lsmtr_pkg::UNMAPPED_DATA;
    case (ptr_reg)
      lsmtr_pkg::SUPPLY_CFG_ADDR: rd_data = {2'b00, supply_cfg_reg};
      lsmtr_pkg::LAST_LEVEL_ADDR: rd_data = last_level_reg;
      lsmtr_pkg::TORCH_ADDR:      rd_data = {2'b00, torch_reg};
      lsmtr_pkg::FLAGS_ADDR: begin
        rd_data[lsmtr_pkg::FLAG_THERM_BIT]  = flags_reg.therm_trip;
        rd_data[lsmtr_pkg::FLAG_STEADY_BIT] = flags_reg.steady_trip;
        rd_data[lsmtr_pkg::FLAG_FLASH_BIT]  = flags_reg.flash_trip;
      end
      default: rd_data = lsmtr_pkg::UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    wr_stb_reg   <= 1'b0;
    flag_clr_reg <= 1'b0;
    if (rst_in) begin
      state_reg   <= lsmtr_pkg::ST_IDLE;
      shift_reg   <= 8'h00;
      bit_cnt_reg <= 4'h0;
      ptr_reg     <= 8'h00;
      rw_reg      <= 1'b0;
      ack_ok_reg  <= 1'b0;
      sda_oe_reg  <= 1'b0;
      sda_o_reg   <= 1'b0;
      wr_ptr_reg  <= 8'h00;
      wr_data_reg <= 8'h00;
    end else if (start_det) begin
      state_reg   <= lsmtr_pkg::ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg  <= 1'b0;
    end else if (stop_det) begin
      state_reg  <= lsmtr_pkg::ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        lsmtr_pkg::ST_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        lsmtr_pkg::ST_ADDR, lsmtr_pkg::ST_REG, lsmtr_pkg::ST_WDATA: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_sync};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == lsmtr_pkg::BYTE_BITS) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == lsmtr_pkg::ST_ADDR) begin
              if (shift_reg[7:1] == DEV_ADDR) begin
                rw_reg     <= shift_reg[0];
                sda_oe_reg <= 1'b1;
                state_reg  <= lsmtr_pkg::ST_ACK_ADDR;
              end else begin
                state_reg <= lsmtr_pkg::ST_IDLE;
              end
            end else if (state_reg == lsmtr_pkg::ST_REG) begin
              ptr_reg    <= shift_reg;
              sda_oe_reg <= 1'b1;
              state_reg  <= lsmtr_pkg::ST_ACK_REG;
            end else begin
              // writes to the read-only or unmapped addresses are acked and dropped later
              wr_stb_reg  <= 1'b1;
              wr_ptr_reg  <= ptr_reg;
              wr_data_reg <= shift_reg;
              ptr_reg     <= ptr_reg + 8'h01;
              sda_oe_reg  <= 1'b1;
              state_reg   <= lsmtr_pkg::ST_ACK_WR;
            end
          end
        end
        lsmtr_pkg::ST_ACK_ADDR: begin
          if (scl_fall) begin
            if (rw_reg) begin
              shift_reg    <= {rd_data[6:0], 1'b0};
              sda_oe_reg   <= !rd_data[7];
              bit_cnt_reg  <= 4'h1;
              ptr_reg      <= ptr_reg + 8'h01;
              flag_clr_reg <= (ptr_reg == lsmtr_pkg::FLAGS_ADDR);
              state_reg    <= lsmtr_pkg::ST_RDATA;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg  <= lsmtr_pkg::ST_REG;
            end
          end
        end
        lsmtr_pkg::ST_ACK_REG, lsmtr_pkg::ST_ACK_WR: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            state_reg  <= lsmtr_pkg::ST_WDATA;
          end
        end
        lsmtr_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_reg == lsmtr_pkg::BYTE_BITS) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= lsmtr_pkg::ST_RACK;
            end else begin
              sda_oe_reg  <= !shift_reg[7];
              shift_reg   <= {shift_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        lsmtr_pkg::ST_RACK: begin
          if (scl_rise) begin
            ack_ok_reg <= !sda_sync;
          end else if (scl_fall) begin
            if (ack_ok_reg) begin
              shift_reg    <= {rd_data[6:0], 1'b0};
              sda_oe_reg   <= !rd_data[7];
              bit_cnt_reg  <= 4'h1;
              ptr_reg      <= ptr_reg + 8'h01;
              flag_clr_reg <= (ptr_reg == lsmtr_pkg::FLAGS_ADDR);
              state_reg    <= lsmtr_pkg::ST_RDATA;
            end else begin
              state_reg <= lsmtr_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // writable registers
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      supply_cfg_reg <= lsmtr_pkg::SUPPLY_CFG_RST;
      torch_reg      <= lsmtr_pkg::TORCH_RST;
    end else if (wr_stb_reg) begin
      case (wr_ptr_reg)
        lsmtr_pkg::SUPPLY_CFG_ADDR: supply_cfg_reg <= wr_data_reg[5:0];
        lsmtr_pkg::TORCH_ADDR:      torch_reg      <= wr_data_reg[5:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // trip qualification
  lsmtr_deglitch #(
    .CYCLES (lsmtr_pkg::STEADY_CYCLES),
    .CNT_W  (lsmtr_pkg::DEGLITCH_CNT_W)
  ) u_therm_deglitch (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .enable_in   (thermistor_sensing_in),
    .level_in    (therm_sync),
    .fire_out    (fire_therm)
  );

  lsmtr_deglitch #(
    .CYCLES (lsmtr_pkg::STEADY_CYCLES),
    .CNT_W  (lsmtr_pkg::DEGLITCH_CNT_W)
  ) u_steady_deglitch (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .enable_in   (supply_cfg_reg.steady_monitor_en),
    .level_in    (stdy_sync),
    .fire_out    (fire_steady)
  );

  lsmtr_deglitch #(
    .CYCLES (lsmtr_pkg::FLASH_CYCLES),
    .CNT_W  (lsmtr_pkg::DEGLITCH_CNT_W)
  ) u_flash_deglitch (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .enable_in   (supply_cfg_reg.flash_monitor_en),
    .level_in    (fls_sync),
    .fire_out    (fire_flash)
  );

  assign fire     = {fire_flash, fire_steady, fire_therm};
  assign any_fire = |fire;

  // ==========================================================================
  // capture and flags, set wins over clear on read
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      last_level_reg <= lsmtr_pkg::LAST_LEVEL_RST;
    end else if (any_fire) begin
      last_level_reg <= flash_code_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      flags_reg <= lsmtr_pkg::FLAGS_RST;
    end else begin
      flags_reg <= (flags_reg & ~{3{flag_clr_reg}}) | fire;
    end
  end

  assign sda_out         = sda_o_reg;
  assign sda_oe_out      = sda_oe_reg;
  assign supply_cfg_out  = supply_cfg_reg;
  assign torch_cfg_out   = torch_reg;
  assign last_level_out  = last_level_reg;
  assign fault_flags_out = flags_reg;

  // ==========================================================================
  // checks
  steady_enable_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    wr_stb_reg && wr_ptr_reg == lsmtr_pkg::SUPPLY_CFG_ADDR
    |=> supply_cfg_out.steady_monitor_en == $past(wr_data_reg[0]))
    else $error("steady monitor enable not taken from write");
  steady_thresh_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    wr_stb_reg && wr_ptr_reg == lsmtr_pkg::SUPPLY_CFG_ADDR
    |=> supply_cfg_out.steady_supply_threshold == $past(wr_data_reg[2:1]))
    else $error("steady threshold not taken from write");
  flash_enable_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    wr_stb_reg && wr_ptr_reg == lsmtr_pkg::SUPPLY_CFG_ADDR
    |=> supply_cfg_out.flash_monitor_en == $past(wr_data_reg[3]))
    else $error("flash monitor enable not taken from write");
  flash_thresh_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    wr_stb_reg && wr_ptr_reg == lsmtr_pkg::SUPPLY_CFG_ADDR
    |=> supply_cfg_out.flash_supply_threshold == $past(wr_data_reg[5:4]))
    else $error("flash threshold not taken from write");
  therm_gated_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    fire.therm_trip |-> $past(thermistor_sensing_in)
    ##1 last_level_out == $past(flash_code_in) && fault_flags_out.therm_trip)
    else $error("thermistor capture wrong or ungated");
  supply_capture_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    fire.steady_trip || fire.flash_trip
    |=> last_level_out[3:0] == $past(flash_code_in[3:0])
        && last_level_out[7:4] == $past(flash_code_in[7:4]))
    else $error("supply trip did not capture flash codes");
  last_level_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !any_fire |=> $stable(last_level_out))
    else $error("last level changed without a trip");
  torch_write_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    wr_stb_reg && wr_ptr_reg == lsmtr_pkg::TORCH_ADDR
    |=> torch_cfg_out.torch_led1_code == $past(wr_data_reg[2:0])
        && torch_cfg_out.torch_led2_code == $past(wr_data_reg[5:3]))
    else $error("torch codes not taken from write");
  flags_clear_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    flag_clr_reg && !any_fire |=> fault_flags_out == 3'h0)
    else $error("flags not cleared by flags read");

endmodule : lsmtr_regs

// File: verif/lsmtr_host_model.sv
// bit-level host model of the serial register bus
`timescale 1ns/1ns

module lsmtr_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  input  wire logic core_clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : wait_clk

  // data moves mid-low, after the device has seen the fall
  task automatic put_bit(input logic b, output logic r);
    wait_clk(5);
    sda_low_out <= ~b;
    wait_clk(3);
    scl_out <= 1'b1;
    wait_clk(8);
    r = sda_in;
    scl_out <= 1'b0;
  endtask : put_bit

  task automatic start_cond();
    wait_clk(5);
    sda_low_out <= 1'b0;
    wait_clk(3);
    scl_out <= 1'b1;
    wait_clk(8);
    sda_low_out <= 1'b1;
    wait_clk(8);
    scl_out <= 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    wait_clk(5);
    sda_low_out <= 1'b1;
    wait_clk(3);
    scl_out <= 1'b1;
    wait_clk(8);
    sda_low_out <= 1'b0;
    wait_clk(8);
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], r);
    end
    put_bit(1'b1, r);
    ack = ~r;
  endtask : send_byte

  // last byte is answered with a release, others pulled low
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      put_bit(1'b1, r);
      d = {d[6:0], r};
    end
    put_bit(last, r);
  endtask : recv_byte

  // a foreign address must go unanswered
  task automatic probe_addr(input logic [6:0] dev, output logic ack);
    start_cond();
    send_byte({dev, 1'b0}, ack);
    stop_cond();
  endtask : probe_addr

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start_cond();
    send_byte({DEV_ADDR, 1'b0}, k0);
    send_byte(a, k1);
    send_byte(d, k2);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start_cond();
    send_byte({DEV_ADDR, 1'b0}, k0);
    send_byte(a, k1);
    start_cond();
    send_byte({DEV_ADDR, 1'b1}, k2);
    recv_byte(1'b1, d);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask : read_reg
endmodule : lsmtr_host_model

// File: verif/tb.sv
// self-checking bench for the supply monitor and torch register bank
`timescale 1ns/1ns

module tb;
  logic                         core_clk_in;
  logic                         rst_in;
  logic                         scl;
  logic                         sda_low;
  logic                         sda;
  logic                         sda_out;
  logic                         sda_oe;
  logic [7:0]                   flash_code;
  logic                         sensing;
  logic                         therm_trip;
  logic                         steady_low;
  logic                         flash_low;
  lsmtr_pkg::lsmtr_supply_cfg_t supply_cfg;
  lsmtr_pkg::lsmtr_torch_t      torch_cfg;
  logic [7:0]                   last_level;
  lsmtr_pkg::lsmtr_flags_t      flags;
  int                           n_errors;
  int                           samples_checked;
  logic [7:0]                   rd;
  logic                         ok;

  // open-drain line with pull-up
  assign sda = ~(sda_low | (sda_oe & ~sda_out));

  lsmtr_regs u_dut (
    .core_clk_in          (core_clk_in),
    .rst_in               (rst_in),
    .scl_in               (scl),
    .sda_in               (sda),
    .sda_out              (sda_out),
    .sda_oe_out           (sda_oe),
    .flash_code_in        (flash_code),
    .thermistor_sensing_in(sensing),
    .thermistor_trip_in   (therm_trip),
    .steady_supply_low_in (steady_low),
    .flash_supply_low_in  (flash_low),
    .supply_cfg_out       (supply_cfg),
    .torch_cfg_out        (torch_cfg),
    .last_level_out       (last_level),
    .fault_flags_out      (flags)
  );

  lsmtr_host_model u_host (
    .core_clk_in(core_clk_in),
    .sda_in     (sda),
    .scl_out    (scl),
    .sda_low_out(sda_low)
  );

  // ==========================================================================
  // checking and closing
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.write_reg(a, d, ok);
    check("write ack", {7'h00, ok}, 8'h01);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    u_host.read_reg(a, rd, ok);
    check("read ack", {7'h00, ok}, 8'h01);
    check(what, rd, exp);
  endtask : rd_chk

  // ==========================================================================
  // scenarios
  task automatic test_reset_values();
    check("cfg port", {2'b00, supply_cfg}, 8'h00);
    check("torch port", {2'b00, torch_cfg}, 8'h12);
    check("last port", last_level, 8'h00);
    rd_chk("cfg read", lsmtr_pkg::SUPPLY_CFG_ADDR, 8'h00);
    rd_chk("torch read", lsmtr_pkg::TORCH_ADDR, 8'h12);
    rd_chk("last read", lsmtr_pkg::LAST_LEVEL_ADDR, 8'h00);
  endtask : test_reset_values

  task automatic test_config_regs();
    logic [7:0] cv [4];
    logic [7:0] tv [4];
    cv = '{8'h0B, 8'h35, 8'hDF, 8'h20};
    tv = '{8'hC7, 8'h38, 8'h2A, 8'h12};
    for (int i = 0; i < 4; i++) begin
      wr(lsmtr_pkg::SUPPLY_CFG_ADDR, cv[i]);
      check("cfg port", {2'b00, supply_cfg}, {2'b00, cv[i][5:0]});
      rd_chk("cfg read", lsmtr_pkg::SUPPLY_CFG_ADDR, {2'b00, cv[i][5:0]});
      wr(lsmtr_pkg::TORCH_ADDR, tv[i]);
      check("torch led1", {5'h00, torch_cfg.torch_led1_code}, {5'h00, tv[i][2:0]});
      check("torch led2", {5'h00, torch_cfg.torch_led2_code}, {5'h00, tv[i][5:3]});
      rd_chk("torch read", lsmtr_pkg::TORCH_ADDR, {2'b00, tv[i][5:0]});
    end
  endtask : test_config_regs

  task automatic test_flash_trip();
    wr(lsmtr_pkg::SUPPLY_CFG_ADDR, 8'h08);
    @(posedge core_clk_in);
    flash_code <= 8'hA5;
    flash_low  <= 1'b1;
    repeat (80) @(posedge core_clk_in);
    check("last early", last_level, 8'h00);
    repeat (6) @(posedge core_clk_in);
    check("last flash", last_level, 8'hA5);
    check("flash flag", {7'h00, flags.flash_trip}, 8'h01);
    flash_code <= 8'h11;
    flash_low  <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    check("last held", last_level, 8'hA5);
  endtask : test_flash_trip

  task automatic test_steady_trip();
    wr(lsmtr_pkg::SUPPLY_CFG_ADDR, 8'h01);
    @(posedge core_clk_in);
    flash_code <= 8'h3C;
    steady_low <= 1'b1;
    repeat (2495) @(posedge core_clk_in);
    check("last early", last_level, 8'hA5);
    repeat (15) @(posedge core_clk_in);
    check("last steady", last_level, 8'h3C);
    check("steady flag", {7'h00, flags.steady_trip}, 8'h01);
    steady_low <= 1'b0;
  endtask : test_steady_trip

  task automatic test_disabled_and_thermistor();
    wr(lsmtr_pkg::SUPPLY_CFG_ADDR, 8'h00);
    @(posedge core_clk_in);
    flash_code <= 8'h7E;
    therm_trip <= 1'b1;
    steady_low <= 1'b1;
    flash_low  <= 1'b1;
    repeat (2600) @(posedge core_clk_in);
    check("last disabled", last_level, 8'h3C);
    therm_trip <= 1'b0;
    steady_low <= 1'b0;
    flash_low  <= 1'b0;
    sensing    <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    therm_trip <= 1'b1;
    repeat (2495) @(posedge core_clk_in);
    check("last early", last_level, 8'h3C);
    repeat (15) @(posedge core_clk_in);
    check("last thermistor", last_level, 8'h7E);
    therm_trip <= 1'b0;
  endtask : test_disabled_and_thermistor

  task automatic test_read_only_and_flags();
    wr(lsmtr_pkg::LAST_LEVEL_ADDR, 8'hFF);
    check("last after write", last_level, 8'h7E);
    rd_chk("last read", lsmtr_pkg::LAST_LEVEL_ADDR, 8'h7E);
    rd_chk("flags read", lsmtr_pkg::FLAGS_ADDR, 8'h70);
    check("flags port", {5'h00, flags}, 8'h00);
    rd_chk("flags again", lsmtr_pkg::FLAGS_ADDR, 8'h00);
    u_host.probe_addr(7'h2B, ok);
    check("foreign address ack", {7'h00, ok}, 8'h00);
    rd_chk("unmapped", 8'h90, 8'h00);
  endtask : test_read_only_and_flags

  // ==========================================================================
  // clock, reset, sequence and watchdog
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end

  initial begin
    n_errors        = 0;
    samples_checked = 0;
    rst_in          = 1'b1;
    flash_code      = 8'h00;
    sensing         = 1'b0;
    therm_trip      = 1'b0;
    steady_low      = 1'b0;
    flash_low       = 1'b0;
    repeat (3) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    test_reset_values();
    test_config_regs();
    test_flash_trip();
    test_steady_trip();
    test_disabled_and_thermistor();
    test_read_only_and_flags();
    report_and_stop();
  end

  initial begin
    repeat (60000) @(posedge core_clk_in);
    n_errors++;
    report_and_stop();
  end
endmodule : tb
